//--- logic/acf_params.svh
// Purpose: Constants of the converter control block: offsets, fields, timing
// Assumes: 10 MHz master clock feeds clk_i
// Notes:   Definitions only
`ifndef ACF_PARAMS_SVH
`define ACF_PARAMS_SVH

// Master clock and filter decimation
`define ACF_CLK_HZ          10000000
`define ACF_DECIM           512
`define ACF_RATE_DEFAULT_HZ 60
`define ACF_NOTCH_RESET     12'((2 * `ACF_CLK_HZ / \
	(`ACF_DECIM * `ACF_RATE_DEFAULT_HZ) + 1) / 2)
`define ACF_CODE_MIN        12'h013
`define ACF_CODE_MAX        12'h7d0

// Settling, in output word periods
`define ACF_SETTLE_STEP     3'h4
`define ACF_SETTLE_SYNC     3'h3
`define ACF_SETTLE_CHAN     3'h3

// Register byte offsets
`define ACF_ADDR_CONTROL    8'h00
`define ACF_ADDR_STATUS     8'h04
`define ACF_ADDR_COEF_SEL   8'h08
`define ACF_ADDR_COEF_DATA  8'h0c
`define ACF_ADDR_WORD_COUNT 8'h10

// Control register field positions
`define ACF_F_NOTCH_LO      0
`define ACF_F_NOTCH_HI      11
`define ACF_F_UNIPOLAR      12
`define ACF_F_BURNOUT       13
`define ACF_F_COMP          14
`define ACF_F_WORD24        15
`define ACF_F_SLEEP         16
`define ACF_F_PAIR          17
`define ACF_F_GAIN_LO       18
`define ACF_F_GAIN_HI       20

// Reset values
`define ACF_GAIN_RESET      3'h0
`define ACF_COEF_RESET      24'h000000

`endif

//--- logic/acf_pkg.sv
// Purpose: Types of the converter control block
// Assumes: Constants come from acf_params.svh
// Notes:   Every module keeps its whole state in one struct from here
package acf_pkg;

	// Configuration held in the control register
	typedef struct packed {
		logic [2:0]  gain_code;
		logic        pair_sel;
		logic        sleep;
		logic        word24;
		logic        comp_on;
		logic        burnout_on;
		logic        unipolar;
		logic [11:0] notch_code;
	} acf_cfg_s;

	// Settings driven toward the analog front end
	typedef struct packed {
		logic [7:0] gain_factor;
		logic       second_pair;
		logic       sleep;
		logic       word24;
		logic       comp_on;
		logic       burnout_on;
		logic       unipolar;
	} acf_front_s;

	// Coefficient load progress, three bytes high first
	typedef enum logic [1:0] {
		ACF_COEF_IDLE,
		ACF_COEF_ONE,
		ACF_COEF_TWO
	} acf_coef_e;

	// Word timer state
	typedef struct packed {
		logic [15:0] pre;
		logic [11:0] period;
		logic        tick;
	} acf_timer_s;

	// Settling gate state
	typedef struct packed {
		logic [2:0] remain;
	} acf_gate_s;

	// Core state
	typedef struct packed {
		acf_cfg_s              cfg;
		acf_front_s            front;
		logic [1:0][23:0]      coef_zero;
		logic [1:0][23:0]      coef_full;
		logic                  coef_full_sel;
		acf_coef_e             coef_state;
		logic [15:0]           coef_stage;
		logic                  sync_meta;
		logic                  sync_sync;
		logic                  sync_prev;
		logic                  new_word;
		logic                  ready;
		logic [15:0]           word_count;
		logic [31:0]           rdata;
	} acf_core_s;

endpackage

//--- logic/acf_word_timer.sv
// Purpose: Output word period counter, DECIM times the notch code
// Assumes: Code held stable by the caller between clears
// Notes:   Codes 0 and 1 both give one prescaler period
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_word_timer #(
	parameter int DECIM = `ACF_DECIM
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Control
	input  wire logic        clear_i,
	input  wire logic [11:0] code_i,
	// Word period event
	output logic             tick_o
);
	localparam logic [15:0] PRE_LAST = 16'(DECIM - 1);

	acf_pkg::acf_timer_s r, nxt;

	if (DECIM < 2 || DECIM > 65536) begin : g_check
		$error("acf_word_timer: DECIM out of range");
	end

	// Prescale by DECIM, then count notch code periods
	always_comb begin
		nxt = r;
		nxt.tick = 1'b0;
		if (clear_i) begin
			nxt.pre = 16'h0000;
			nxt.period = 12'h000;
		end else if (r.pre == PRE_LAST) begin
			nxt.pre = 16'h0000;
			if ({1'b0, r.period} + 13'h0001 >= {1'b0, code_i}) begin
				nxt.period = 12'h000;
				nxt.tick = 1'b1;
			end else begin
				nxt.period = r.period + 12'h001;
			end
		end else begin
			nxt.pre = r.pre + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r <= '0;
		end else begin
			r <= nxt;
		end
	end

	assign tick_o = r.tick;
endmodule

//--- logic/acf_settle_gate.sv
// Purpose: Holds back word events until the filter has settled
// Assumes: One tick per output word period
// Notes:   A new load replaces the count, even a larger pending one
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_settle_gate (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Settling requests
	input  wire logic       load_i,
	input  wire logic [2:0] load_val_i,
	// Word periods
	input  wire logic       tick_i,
	output logic            pass_o,
	output logic [2:0]      remain_o
);
	acf_pkg::acf_gate_s r, nxt;

	// Count word periods down to settled
	always_comb begin
		nxt = r;
		if (load_i) begin
			nxt.remain = load_val_i;
		end else if (tick_i && r.remain != 3'h0) begin
			nxt.remain = r.remain - 3'h1;
		end
	end

	// State register, settling from power-on as after a step
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r.remain <= `ACF_SETTLE_STEP;
		end else begin
			r <= nxt;
		end
	end

	// Word at the last settling period is already settled
	assign pass_o = tick_i && !load_i && r.remain <= 3'h1;
	assign remain_o = r.remain;
endmodule

//--- logic/acf_core.sv
// Purpose: Control register, coefficient access and word rate of the
//          sigma-delta converter's digital side
// Assumes: Single 10 MHz clock; sync pin is asynchronous to it
// Notes:   Register port answers reads in the following cycle
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
`include "acf_params.svh"

module acf_core #(
	parameter int DECIM = `ACF_DECIM
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Register port
	input  wire logic [7:0]         addr_i,
	input  wire logic [31:0]        wdata_i,
	input  wire logic               wr_i,
	input  wire logic               rd_i,
	output logic [31:0]             rdata_o,
	// Filter sync pin, low holds filter in reset
	input  wire logic               sync_n_i,
	// Front end settings
	output acf_pkg::acf_front_s     front_o,
	// Word events
	output logic                    word_ready_o,
	output logic                    settled_o,
	output logic                    code_fault_o
);
	acf_pkg::acf_core_s r, nxt;

	// Shared combinational terms
	logic               ctrl_wr;
	logic               status_rd;
	logic               sel_wr;
	logic               data_wr;
	acf_pkg::acf_cfg_s  cfg_new;
	logic               pair_change;
	logic               code_change;
	logic               wake;
	logic               sync_low;
	logic               sync_rise;
	logic               timer_clear;
	logic               settle_load;
	logic [2:0]         settle_val;
	logic               tick;
	logic               pass;
	logic [2:0]         remain;
	logic               fault;
	logic               settled;
	logic [7:0]         gain_factor;
	logic [31:0]        ctrl_word;
	logic [31:0]        status_word;

	// Prescaler is sixteen bits wide and needs two states at least
	if (DECIM < 2 || DECIM > 65536) begin : g_check
		$error("acf_core: DECIM out of range");
	end

	// Address decode
	assign ctrl_wr   = wr_i && addr_i == `ACF_ADDR_CONTROL;
	assign sel_wr    = wr_i && addr_i == `ACF_ADDR_COEF_SEL;
	assign data_wr   = wr_i && addr_i == `ACF_ADDR_COEF_DATA;
	assign status_rd = rd_i && addr_i == `ACF_ADDR_STATUS;

	// Control word as it would be written
	always_comb begin
		cfg_new = r.cfg;
		if (ctrl_wr) begin
			cfg_new.gain_code  = wdata_i[`ACF_F_GAIN_HI:`ACF_F_GAIN_LO];
			cfg_new.pair_sel   = wdata_i[`ACF_F_PAIR];
			cfg_new.sleep      = wdata_i[`ACF_F_SLEEP];
			cfg_new.word24     = wdata_i[`ACF_F_WORD24];
			cfg_new.comp_on    = wdata_i[`ACF_F_COMP];
			cfg_new.burnout_on = wdata_i[`ACF_F_BURNOUT];
			cfg_new.unipolar   = wdata_i[`ACF_F_UNIPOLAR];
			cfg_new.notch_code =
				wdata_i[`ACF_F_NOTCH_HI:`ACF_F_NOTCH_LO];
		end
	end

	// Gain code to amplifier factor, doubling per step;
	// code 0 is the power-on gain of one
	always_comb begin
		unique case (cfg_new.gain_code)
			3'h0: gain_factor = 8'h01;
			3'h1: gain_factor = 8'h02;
			3'h2: gain_factor = 8'h04;
			3'h3: gain_factor = 8'h08;
			3'h4: gain_factor = 8'h10;
			3'h5: gain_factor = 8'h20;
			3'h6: gain_factor = 8'h40;
			3'h7: gain_factor = 8'h80;
		endcase
	end

	// Events that restart filter settling
	assign pair_change = cfg_new.pair_sel != r.cfg.pair_sel;
	assign code_change = cfg_new.notch_code != r.cfg.notch_code;
	assign wake        = r.cfg.sleep && !cfg_new.sleep;
	assign sync_low    = !r.sync_sync;
	assign sync_rise   = r.sync_sync && !r.sync_prev;

	// Filter held in reset by sync, sleep or a new code; restarting on
	// a new code keeps the first period from mixing two code lengths
	assign timer_clear = sync_low || r.cfg.sleep || code_change;

	// Settling length: a full step needs four, sync or channel three
	// One write may change code and pair at once; the longer count wins
	always_comb begin
		settle_load = 1'b0;
		settle_val  = `ACF_SETTLE_SYNC;
		if (code_change || wake) begin
			settle_load = 1'b1;
			settle_val  = `ACF_SETTLE_STEP;
		end else if (pair_change) begin
			settle_load = 1'b1;
			settle_val  = `ACF_SETTLE_CHAN;
		end else if (sync_rise) begin
			settle_load = 1'b1;
			settle_val  = `ACF_SETTLE_SYNC;
		end
	end

	// Software is trusted with the code range; only flagged here
	assign fault = r.cfg.notch_code < `ACF_CODE_MIN ||
		r.cfg.notch_code > `ACF_CODE_MAX;

	// Settled once the gate has no periods left to wait
	assign settled = remain == 3'h0;

	// Control register as read back
	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[`ACF_F_GAIN_HI:`ACF_F_GAIN_LO] = r.cfg.gain_code;
		ctrl_word[`ACF_F_PAIR]     = r.cfg.pair_sel;
		ctrl_word[`ACF_F_SLEEP]    = r.cfg.sleep;
		ctrl_word[`ACF_F_WORD24]   = r.cfg.word24;
		ctrl_word[`ACF_F_COMP]     = r.cfg.comp_on;
		ctrl_word[`ACF_F_BURNOUT]  = r.cfg.burnout_on;
		ctrl_word[`ACF_F_UNIPOLAR] = r.cfg.unipolar;
		ctrl_word[`ACF_F_NOTCH_HI:`ACF_F_NOTCH_LO] =
			r.cfg.notch_code;
	end

	// Status bits; settled and remain come from the gate register,
	// so software sees the same count that holds words back
	always_comb begin
		status_word       = 32'h0000_0000;
		status_word[0]    = settled;
		status_word[1]    = r.new_word;
		status_word[2]    = fault;
		status_word[3]    = sync_low;
		status_word[5:4]  = r.coef_state;
		status_word[10:8] = remain;
	end

	// Word period counter
	acf_word_timer #(
		.DECIM    (DECIM)
	) u_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clear_i  (timer_clear),
		.code_i   (r.cfg.notch_code),
		.tick_o   (tick)
	);

	// Settling gate
	acf_settle_gate u_gate (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.load_i     (settle_load),
		.load_val_i (settle_val),
		.tick_i     (tick),
		.pass_o     (pass),
		.remain_o   (remain)
	);

	// Next state
	always_comb begin
		nxt = r;
		nxt.cfg = cfg_new;

		// Sync pin through two flops, then edge history; only the second
		// flop is read, the first may still be settling
		nxt.sync_meta = sync_n_i;
		nxt.sync_sync = r.sync_meta;
		nxt.sync_prev = r.sync_sync;

		// Decode settings for the front end
		nxt.front.gain_factor = gain_factor;
		nxt.front.second_pair = cfg_new.pair_sel;
		nxt.front.sleep       = cfg_new.sleep;
		nxt.front.word24      = cfg_new.word24;
		nxt.front.comp_on     = cfg_new.comp_on;
		nxt.front.burnout_on  = cfg_new.burnout_on;
		nxt.front.unipolar    = cfg_new.unipolar;

		// Word events, one per settled period
		// A word passing the gate in the cycle sleep is written still lands; later ones are dropped
		nxt.ready = pass && !r.cfg.sleep;
		if (sync_low) begin
			nxt.word_count = 16'h0000;
		end else if (r.ready) begin
			nxt.word_count = r.word_count + 16'h0001;
		end

		// New-word flag: set beats a clearing status read,
		// so a word that lands with the read is still reported
		if (r.ready) begin
			nxt.new_word = 1'b1;
		end else if (status_rd) begin
			nxt.new_word = 1'b0;
		end

		// Coefficient bank select; abandons a partial word
		if (sel_wr) begin
			nxt.coef_full_sel = wdata_i[0];
		end

		// Coefficient load, high byte first, 24 bits or nothing
		// A partial word never reaches a bank; stray bytes join the next word unless a select or control write drops them
		if (sel_wr || ctrl_wr) begin
			nxt.coef_state = acf_pkg::ACF_COEF_IDLE;
			nxt.coef_stage = 16'h0000;
		end else if (data_wr) begin
			unique case (r.coef_state)
				acf_pkg::ACF_COEF_IDLE: begin
					nxt.coef_stage[15:8] = wdata_i[7:0];
					nxt.coef_state = acf_pkg::ACF_COEF_ONE;
				end
				acf_pkg::ACF_COEF_ONE: begin
					nxt.coef_stage[7:0] = wdata_i[7:0];
					nxt.coef_state = acf_pkg::ACF_COEF_TWO;
				end
				acf_pkg::ACF_COEF_TWO: begin
					nxt.coef_state = acf_pkg::ACF_COEF_IDLE;
					if (r.coef_full_sel) begin
						nxt.coef_full[r.cfg.pair_sel] =
							{r.coef_stage, wdata_i[7:0]};
					end else begin
						nxt.coef_zero[r.cfg.pair_sel] =
							{r.coef_stage, wdata_i[7:0]};
					end
				end
				default: begin
					nxt.coef_state = acf_pkg::ACF_COEF_IDLE;
				end
			endcase
		end

		// Read data, valid only in the cycle after the strobe
		nxt.rdata = 32'h0000_0000;
		if (rd_i) begin
			unique case (addr_i)
				`ACF_ADDR_CONTROL: begin
					nxt.rdata = ctrl_word;
				end
				`ACF_ADDR_STATUS: begin
					nxt.rdata = status_word;
				end
				`ACF_ADDR_COEF_SEL: begin
					nxt.rdata[0] = r.coef_full_sel;
				end
				`ACF_ADDR_COEF_DATA: begin
					// Always the whole 24-bit word
					nxt.rdata[23:0] = r.coef_full_sel ?
						r.coef_full[r.cfg.pair_sel] :
						r.coef_zero[r.cfg.pair_sel];
				end
				`ACF_ADDR_WORD_COUNT: begin
					nxt.rdata[15:0] = r.word_count;
				end
				default: begin
					nxt.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register with power-on values; the sync flops start high
	// so that leaving reset is not taken for a sync release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r.cfg.gain_code   <= `ACF_GAIN_RESET;
			r.cfg.pair_sel    <= 1'b0;
			r.cfg.sleep       <= 1'b0;
			r.cfg.word24      <= 1'b0;
			r.cfg.comp_on     <= 1'b0;
			r.cfg.burnout_on  <= 1'b0;
			r.cfg.unipolar    <= 1'b0;
			r.cfg.notch_code  <= `ACF_NOTCH_RESET;
			r.front.gain_factor <= 8'h01;
			r.front.second_pair <= 1'b0;
			r.front.sleep       <= 1'b0;
			r.front.word24      <= 1'b0;
			r.front.comp_on     <= 1'b0;
			r.front.burnout_on  <= 1'b0;
			r.front.unipolar    <= 1'b0;
			r.coef_zero     <= {2{`ACF_COEF_RESET}};
			r.coef_full     <= {2{`ACF_COEF_RESET}};
			r.coef_full_sel <= 1'b0;
			r.coef_state    <= acf_pkg::ACF_COEF_IDLE;
			r.coef_stage    <= 16'h0000;
			r.sync_meta     <= 1'b1;
			r.sync_sync     <= 1'b1;
			r.sync_prev     <= 1'b1;
			r.new_word      <= 1'b0;
			r.ready         <= 1'b0;
			r.word_count    <= 16'h0000;
			r.rdata         <= 32'h0000_0000;
		end else begin
			r <= nxt;
		end
	end

	// Outputs
	assign rdata_o      = r.rdata;
	assign front_o      = r.front;
	assign word_ready_o = r.ready;
	assign settled_o    = settled;
	assign code_fault_o = fault;
endmodule

//--- bench/acf_host_model.sv
// Purpose: Microcontroller side of the register port
// Assumes: One-cycle strobes, read data one cycle later
// Notes:   Released lines show the inverse of the last value
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_host_model (
	// Clock and read data
	input wire logic		clk_i,
	input wire logic [31:0]	rdata_i,
	// Request lines
	output logic [7:0]		addr_o,
	output logic [31:0]		wdata_o,
	output logic			wr_o,
	output logic			rd_o
);
	// Idle bus at time zero
	initial begin
		addr_o = 8'h00;
		wdata_o = 32'h0;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One write cycle
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		addr_o <= ~a;
		wdata_o <= ~d;
	endtask
	// One read cycle, data taken mid-way through the cycle after
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		addr_o <= ~a;
		@(negedge clk_i);
		d = rdata_i;
	endtask
	// Whole coefficient, high byte first
	task automatic coef_word(input logic [23:0] c);
		for (int i = 2; i >= 0; i--) begin
			wr_reg(`ACF_ADDR_COEF_DATA, {24'h0, c[8*i +: 8]});
		end
	endtask
endmodule

//--- bench/acf_core_sva.sv
// Purpose: Port checks for the converter control core
// Assumes: Constants from acf_params.svh
// Notes:   Word spacing checked only between undisturbed words
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_core_sva #(
	parameter int DECIM = `ACF_DECIM
) (
	input wire logic				clk_i,
	input wire logic				rst_i,
	input wire logic [7:0]			addr_i,
	input wire logic [31:0]			wdata_i,
	input wire logic				wr_i,
	input wire logic				rd_i,
	input wire logic [31:0]			rdata_o,
	input wire logic				sync_n_i,
	input wire acf_pkg::acf_front_s	front_o,
	input wire logic				word_ready_o,
	input wire logic				settled_o,
	input wire logic				code_fault_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [11:0]	code_r;
	logic			steady_r;
	int				gap_r;
	logic			wc;
	assign wc = wr_i && addr_i == `ACF_ADDR_CONTROL;
	// Cycles since last word, spoiled by control register writes or sync low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			code_r <= `ACF_NOTCH_RESET;
			steady_r <= 1'b0;
			gap_r <= 0;
		end else begin
			if (wc) code_r <= wdata_i[11:0];
			steady_r <= !wc && sync_n_i && (word_ready_o || steady_r);
			gap_r <= word_ready_o ? 1 : gap_r + 1;
		end
	end
	a_gain_decode: assert property (wc |=>
		front_o.gain_factor == 8'h01 << $past(wdata_i[20:18]))
		else $error("gain factor wrong");
	a_pair_follow: assert property (wc |=>
		front_o.second_pair == $past(wdata_i[17])) else $error("pair wrong");
	a_sleep_follow: assert property (wc |=>
		front_o.sleep == $past(wdata_i[16])) else $error("sleep wrong");
	a_switch_bits: assert property (wc |=>
		{front_o.word24, front_o.comp_on, front_o.burnout_on,
		front_o.unipolar} == $past(wdata_i[15:12]))
		else $error("switch bits wrong");
	a_reset_values: assert property ($fell(rst_i) |->
		front_o == {8'h01, 6'h00} && !word_ready_o && !settled_o &&
		!code_fault_o && rdata_o == 32'h0) else $error("reset value wrong");
	a_word_spacing: assert property (word_ready_o && steady_r |->
		gap_r == DECIM * code_r) else $error("word period wrong");
	a_sync_quiet: assert property ((!sync_n_i) [*5] |->
		!word_ready_o) else $error("word during sync low");
	a_sleep_quiet: assert property (front_o.sleep &&
		$past(front_o.sleep) |-> !word_ready_o) else $error("word in sleep");
	a_word_settled: assert property (word_ready_o |->
		settled_o) else $error("word while settling");
	c_word: cover property (word_ready_o);
	c_sync: cover property ((!sync_n_i) [*4]);
	c_sleep: cover property (wc && wdata_i[16]);
endmodule
bind acf_core acf_core_sva #(.DECIM(DECIM)) i_sva (
	.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sync_n_i(sync_n_i),
	.front_o(front_o), .word_ready_o(word_ready_o),
	.settled_o(settled_o), .code_fault_o(code_fault_o));

//--- bench/acf_core_test.sv
// Purpose: Self-checking bench of the converter control core
// Assumes: Short decimation so word periods stay brief
// Notes:   Word timing checked with a small window
`timescale 1ns/1ps
`include "acf_params.svh"
module acf_core_test;
	localparam int DECIM = 2;
	localparam int RST_CODE = (10000000 / 512 + 30) / 60;
	logic			clk_i = 1'b0;
	logic			rst_i = 1'b1;
	logic			sync_n_i = 1'b1;
	logic [7:0]		addr_i;
	logic [31:0]	wdata_i, rdata_o, v, w;
	logic			wr_i, rd_i, word_ready_o, settled_o, code_fault_o, f;
	logic [23:0]	cw;
	acf_pkg::acf_front_s	front_o;
	int				failures = 0, tests_run = 0, seed = 32'hb2de, n, p;
	acf_core #(.DECIM(DECIM)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
		.rdata_o(rdata_o), .sync_n_i(sync_n_i), .front_o(front_o),
		.word_ready_o(word_ready_o), .settled_o(settled_o),
		.code_fault_o(code_fault_o));
	acf_host_model i_host (.clk_i(clk_i), .rdata_i(rdata_o),
		.addr_o(addr_i), .wdata_o(wdata_i), .wr_o(wr_i), .rd_o(rd_i));
	// 10 MHz clock
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	// Expected front end settings from a control word
	function automatic acf_pkg::acf_front_s exp_front(logic [31:0] x);
		return {8'h01 << x[20:18], x[17:12]};
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// Bounded wait for the next word event
	task automatic wait_word(input int lim);
		n = 0;
		f = 1'b0;
		while (!f && n < lim) begin
			@(negedge clk_i);
			n++;
			f = (word_ready_o === 1'b1);
		end
	endtask
	task automatic results;
		$display("%0d checks, %0d failures", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		i_host.rd_reg(`ACF_ADDR_CONTROL, v);
		check(v, RST_CODE);
		check(front_o, exp_front(RST_CODE));
		check(settled_o, 1'b0);
		i_host.rd_reg(8'h14, v);
		check(v, 32'h0);
		p = DECIM * RST_CODE;
		wait_word(4 * p + 8);
		check(f && n >= 4 * p - 8 && n <= 4 * p + 3, 1'b1);
		$display("test 1 done");
		for (int g = 0; g < 8; g++) begin
			w = ($random(seed) & 32'h0001f000) | (g << 18) | 32'h14;
			i_host.wr_reg(`ACF_ADDR_CONTROL, w);
			@(negedge clk_i);
			check(front_o, exp_front(w));
			i_host.rd_reg(`ACF_ADDR_CONTROL, v);
			check(v, w);
		end
		$display("test 2 done");
		for (int k = 0; k < 2; k++) begin
			w = k ? 20 + {$random(seed)} % 16 : 19;
			p = DECIM * w;
			i_host.wr_reg(`ACF_ADDR_CONTROL, w);
			wait_word(4 * p + 8);
			check(f && n >= 4 * p - 1 && n <= 4 * p + 3, 1'b1);
			wait_word(p + 4);
			check(n, p);
			check(code_fault_o, 1'b0);
		end
		$display("test 3 done");
		i_host.wr_reg(`ACF_ADDR_CONTROL, w | 32'h20000);
		wait_word(3 * p + 8);
		check(f && n >= 2 * p - 1 && n <= 3 * p + 3, 1'b1);
		check(front_o.second_pair, 1'b1);
		$display("test 4 done");
		@(posedge clk_i);
		sync_n_i <= 1'b0;
		repeat (3 * p) @(posedge clk_i);
		sync_n_i <= 1'b1;
		wait_word(3 * p + 10);
		check(f && n >= 3 * p && n <= 3 * p + 6, 1'b1);
		i_host.rd_reg(`ACF_ADDR_WORD_COUNT, v);
		check(v, 32'h1);
		i_host.rd_reg(`ACF_ADDR_STATUS, v);
		check(v, 32'h3);
		$display("test 5 done");
		cw = $random(seed);
		i_host.wr_reg(`ACF_ADDR_COEF_SEL, 32'h0);
		i_host.coef_word(cw);
		i_host.rd_reg(`ACF_ADDR_COEF_DATA, v);
		check(v, {8'h00, cw});
		i_host.wr_reg(`ACF_ADDR_COEF_DATA, 32'h5a);
		i_host.wr_reg(`ACF_ADDR_COEF_DATA, 32'ha5);
		i_host.wr_reg(`ACF_ADDR_COEF_SEL, 32'h0);
		i_host.rd_reg(`ACF_ADDR_COEF_DATA, v);
		check(v, {8'h00, cw});
		$display("test 6 done");
		i_host.wr_reg(`ACF_ADDR_CONTROL, w | 32'h10000);
		@(posedge clk_i); // A word already in flight may still land
		wait_word(5 * p);
		check(f, 1'b0);
		$display("test 7 done");
		results();
	end
endmodule
